// ---- src/acc_analog_ctrl.sv ----
// analog compare control and status block with apb register access
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module acc_analog_ctrl (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	input wire logic comp1_out_i,
	input wire logic comp2_out_i,
	input wire logic analog_option_bit_i,
	input wire logic hold_select_i,
	input wire logic second_sample_hold_select_i,
	input wire logic pin4_direction_i,
	input wire logic pin4_data_i,
	input wire logic output_level_bit_i,
	output acc_pkg::acc_analog_t analog_o
);

	acc_pkg::acc_state_t state_reg;
	acc_pkg::acc_state_t state_next;

	logic access;
	logic wr_ctrl;
	logic wr_stat;
	logic live1;
	logic live2;
	logic [7:0] ctrl_view;
	logic [7:0] stat_view;

	always_comb begin
		state_next = state_reg;
		access = psel_i && penable_i && !state_reg.pready;
		wr_ctrl = access && pwrite_i && pstrb_i[0] && paddr_i == acc_pkg::ACC_CTRL_OFFSET;
		wr_stat = access && pwrite_i && pstrb_i[0] && paddr_i == acc_pkg::ACC_STAT_OFFSET;

		state_next.sync1 = {state_reg.sync1[0], comp1_out_i};
		state_next.sync2 = {state_reg.sync2[0], comp2_out_i};
		state_next.comp1_prev = state_reg.sync1[1];
		state_next.comp2_prev = state_reg.sync2[1];
		// live state is forced low while the comparator is unpowered
		live1 = state_reg.sync1[1] && state_reg.comp1_power_enable;
		live2 = state_reg.sync2[1] && state_reg.comp2_power_enable;

		if (wr_ctrl) begin
			state_next.comp2_power_enable = pwdata_i[acc_pkg::ACC_CTRL_COMPARATOR2_POWER_ENABLE_BIT];
			state_next.comp1_power_enable = pwdata_i[acc_pkg::ACC_CTRL_COMPARATOR1_POWER_ENABLE_BIT];
			state_next.ramp_source_enable = pwdata_i[acc_pkg::ACC_CTRL_RAMP_BIT];
			state_next.comparator_irq_enable = pwdata_i[acc_pkg::ACC_CTRL_IRQEN_BIT];
			state_next.mode = acc_pkg::acc_mode_t'({pwdata_i[acc_pkg::ACC_CTRL_MODE_HI_BIT],
				pwdata_i[acc_pkg::ACC_CTRL_MODE_LO_BIT]});
			state_next.charge_drive = pwdata_i[acc_pkg::ACC_CTRL_CHG_BIT];
		end

		if (wr_stat) begin
			// offset bit only stored with option set
			state_next.sample_offset_enable = analog_option_bit_i
				&& pwdata_i[acc_pkg::ACC_STAT_SAMPLE_OFFSET_ENABLE_BIT];
			// pin-output bit only stored with option set
			state_next.comp1_pin_output_enable = analog_option_bit_i
				&& pwdata_i[acc_pkg::ACC_STAT_COMP1_PIN_OUTPUT_ENABLE_BIT];
		end

		// write-one clear of comparator 1 flag
		if (wr_stat && pwdata_i[acc_pkg::ACC_STAT_CLR1_BIT]) begin
			state_next.comp1_rise_flag = 1'b0;
		end
		// write-one clear of comparator 2 flag
		if (wr_stat && pwdata_i[acc_pkg::ACC_STAT_CLR2_BIT]) begin
			state_next.comp2_rise_flag = 1'b0;
		end
		// rising edge sets flag; set beats a same-cycle clear
		if (state_reg.sync1[1] && !state_reg.comp1_prev && state_reg.comp1_power_enable) begin
			state_next.comp1_rise_flag = 1'b1;
		end
		// rising edge sets flag; set beats a same-cycle clear
		if (state_reg.sync2[1] && !state_reg.comp2_prev && state_reg.comp2_power_enable) begin
			state_next.comp2_rise_flag = 1'b1;
		end

		ctrl_view = 8'h00;
		ctrl_view[acc_pkg::ACC_CTRL_COMPARATOR1_POWER_ENABLE_BIT] = state_reg.comp1_power_enable;
		ctrl_view[acc_pkg::ACC_CTRL_COMPARATOR2_POWER_ENABLE_BIT] = state_reg.comp2_power_enable;
		ctrl_view[acc_pkg::ACC_CTRL_RAMP_BIT] = state_reg.ramp_source_enable;
		ctrl_view[acc_pkg::ACC_CTRL_IRQEN_BIT] = state_reg.comparator_irq_enable;
		ctrl_view[acc_pkg::ACC_CTRL_MODE_LO_BIT] = state_reg.mode[0];
		ctrl_view[acc_pkg::ACC_CTRL_MODE_HI_BIT] = state_reg.mode[1];
		ctrl_view[acc_pkg::ACC_CTRL_CHG_BIT] = state_reg.charge_drive;

		stat_view = 8'h00;
		stat_view[acc_pkg::ACC_STAT_FLAG1_BIT] = state_reg.comp1_rise_flag;
		stat_view[acc_pkg::ACC_STAT_FLAG2_BIT] = state_reg.comp2_rise_flag;
		stat_view[acc_pkg::ACC_STAT_SAMPLE_OFFSET_ENABLE_BIT] = state_reg.sample_offset_enable
			&& analog_option_bit_i;
		stat_view[acc_pkg::ACC_STAT_COMP1_PIN_OUTPUT_ENABLE_BIT] = state_reg.comp1_pin_output_enable
			&& analog_option_bit_i;
		stat_view[acc_pkg::ACC_STAT_LIVE1_BIT] = live1;
		stat_view[acc_pkg::ACC_STAT_LIVE2_BIT] = live2;

		// one wait state: answer in the cycle after the access phase starts
		state_next.pready = access;
		state_next.prdata = 32'h0000_0000;
		if (access && !pwrite_i) begin
			if (paddr_i == acc_pkg::ACC_CTRL_OFFSET) begin
				state_next.prdata = {24'h00_0000, ctrl_view};
			end else if (paddr_i == acc_pkg::ACC_STAT_OFFSET) begin
				state_next.prdata = {24'h00_0000, stat_view};
			end
		end

		state_next.ana.comp1_power = state_next.comp1_power_enable;
		state_next.ana.comp2_power = state_next.comp2_power_enable;
		state_next.ana.ramp_power = state_next.ramp_source_enable;
		state_next.ana.support_power = state_next.comp1_power_enable
			|| state_next.comp2_power_enable || state_next.ramp_source_enable;
		state_next.ana.charge_enable = state_next.ramp_source_enable && state_next.charge_drive;
		state_next.ana.discharge_enable = state_next.ramp_source_enable
			&& !state_next.charge_drive;
		// mode is meaningless while ramp disabled
		state_next.ana.mode = state_next.ramp_source_enable ? state_next.mode
			: acc_pkg::ACC_MODE_MANUAL;
		// offset only with both holds clear
		state_next.ana.sample_offset = state_next.sample_offset_enable && analog_option_bit_i
			&& !hold_select_i && !second_sample_hold_select_i;
		state_next.ana.irq = state_next.comparator_irq_enable
			&& (state_next.comp1_rise_flag || state_next.comp2_rise_flag);
		state_next.ana.pin4_out = pin4_data_i || output_level_bit_i
			|| (state_next.comp1_pin_output_enable && analog_option_bit_i
			&& pin4_direction_i && live1);

		// reset clears all control and status
		if (srst_i) begin
			state_next = '0;
		end
	end

	always_ff @(posedge clock_i) begin
		state_reg <= state_next;
	end

	assign pready_o = state_reg.pready;
	assign prdata_o = state_reg.prdata;
	assign pslverr_o = 1'b0;
	assign analog_o = state_reg.ana;

endmodule // acc_analog_ctrl

// ---- src/acc_pkg.sv ----
// package: register map, field positions and carrier types for the analog control block
package acc_pkg;

	// register byte addresses on the apb bus
	localparam logic [7:0] ACC_CTRL_OFFSET = 8'h00;
	localparam logic [7:0] ACC_STAT_OFFSET = 8'h04;

	// analog_power_control field positions
	localparam int ACC_CTRL_COMPARATOR1_POWER_ENABLE_BIT = 0;
	localparam int ACC_CTRL_COMPARATOR2_POWER_ENABLE_BIT = 1;
	localparam int ACC_CTRL_RAMP_BIT = 2;
	localparam int ACC_CTRL_IRQEN_BIT = 3;
	localparam int ACC_CTRL_MODE_LO_BIT = 4;
	localparam int ACC_CTRL_MODE_HI_BIT = 5;
	localparam int ACC_CTRL_CHG_BIT = 6;

	// analog_status_flags field positions
	localparam int ACC_STAT_FLAG1_BIT = 0;
	localparam int ACC_STAT_FLAG2_BIT = 1;
	localparam int ACC_STAT_CLR1_BIT = 2;
	localparam int ACC_STAT_CLR2_BIT = 3;
	localparam int ACC_STAT_SAMPLE_OFFSET_ENABLE_BIT = 4;
	localparam int ACC_STAT_COMP1_PIN_OUTPUT_ENABLE_BIT = 5;
	localparam int ACC_STAT_LIVE1_BIT = 6;
	localparam int ACC_STAT_LIVE2_BIT = 7;

	// reset values
	localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
	localparam logic [7:0] ACC_STAT_RESET = 8'h00;

	// single-slope conversion modes
	typedef enum logic [1:0] {
		ACC_MODE_MANUAL,
		ACC_MODE_MANUAL_DISCHARGE,
		ACC_MODE_TOF_ICF,
		ACC_MODE_OCF_ICF
	} acc_mode_t;

	// analog-facing outputs travel together
	typedef struct packed {
		logic comp1_power;
		logic comp2_power;
		logic ramp_power;
		logic support_power;
		logic charge_enable;
		logic discharge_enable;
		logic sample_offset;
		logic irq;
		logic pin4_out;
		acc_mode_t mode;
	} acc_analog_t;

	// complete state of the block
	typedef struct packed {
		logic comp1_power_enable;
		logic comp2_power_enable;
		logic ramp_source_enable;
		logic comparator_irq_enable;
		acc_mode_t mode;
		logic charge_drive;
		logic comp1_rise_flag;
		logic comp2_rise_flag;
		logic sample_offset_enable;
		logic comp1_pin_output_enable;
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic comp1_prev;
		logic comp2_prev;
		logic pready;
		logic [31:0] prdata;
		acc_analog_t ana;
	} acc_state_t;

endpackage

// ---- dv/acc_analog_ctrl_properties.sv ----
// checker: port relations of the analog control block
module acc_analog_ctrl_properties (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [7:0] paddr_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic analog_option_bit_i,
	input wire logic hold_select_i,
	input wire logic second_sample_hold_select_i,
	input wire logic pin4_data_i,
	input wire logic output_level_bit_i,
	input wire acc_pkg::acc_analog_t analog_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	AST_RESET: assert property ($fell(srst_i) |-> analog_o == '0 && prdata_o == '0)
		else $error("outputs not clear after reset");
	AST_SUPPORT: assert property (analog_o.support_power ==
		(analog_o.comp1_power || analog_o.comp2_power || analog_o.ramp_power))
		else $error("support power mismatch");
	AST_RAMP: assert property (analog_o.ramp_power ==
		(analog_o.charge_enable ^ analog_o.discharge_enable)) else $error("ramp drive mismatch");
	AST_MODE: assert property (!analog_o.ramp_power |-> analog_o.mode == acc_pkg::ACC_MODE_MANUAL)
		else $error("mode active without ramp");
	AST_OFFSET: assert property (analog_o.sample_offset |-> $past(analog_option_bit_i
		&& !hold_select_i && !second_sample_hold_select_i)) else $error("offset while gated");
	AST_PIN4: assert property (!$past(srst_i) && $past(pin4_data_i || output_level_bit_i)
		|-> analog_o.pin4_out) else $error("pin 4 lost its data");
	AST_ANSWER: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
		else $error("ready not a single pulse");
	AST_CLRZERO: assert property (pready_o && $past(paddr_i) == acc_pkg::ACC_STAT_OFFSET
		|-> prdata_o[3:2] == 2'b00) else $error("clear bits read nonzero");
	AST_OPT: assert property (pready_o && $past(paddr_i) == acc_pkg::ACC_STAT_OFFSET
		&& !$past(analog_option_bit_i) |-> prdata_o[5:4] == 2'b00) else $error("gated bits read");
endmodule // acc_analog_ctrl_properties

// ---- dv/acc_far_model.sv ----
// far side: two comparators whose outputs only exist while powered
module acc_far_model (
	input wire logic clock_i,
	input wire logic [1:0] level_i,
	input wire acc_pkg::acc_analog_t analog_i,
	output logic comp1_out_o,
	output logic comp2_out_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial comp1_out_o = 1'b0;
	initial comp2_out_o = 1'b0;
	always @(negedge clock_i) begin
		comp1_out_o <= level_i[0] & analog_i.comp1_power;
		comp2_out_o <= level_i[1] & analog_i.comp2_power;
	end
endmodule // acc_far_model

// ---- dv/tb_top.sv ----
// top-level bench for the analog control block
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] CTRL = acc_pkg::ACC_CTRL_OFFSET;
	localparam logic [7:0] STAT = acc_pkg::ACC_STAT_OFFSET;
	typedef struct {logic [7:0] wr; logic [10:0] ana;} acc_row_t;
	acc_row_t rows [10] = '{'{8'h01, 11'h480}, '{8'h02, 11'h280}, '{8'h04, 11'h1A0},
		'{8'h44, 11'h1C0}, '{8'h40, 11'h000}, '{8'h14, 11'h1A1}, '{8'h24, 11'h1A2},
		'{8'h34, 11'h1A3}, '{8'h30, 11'h000}, '{8'h00, 11'h000}};
	logic clock_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, q;
	logic [3:0] pstrb_i = 4'hF;
	logic [1:0] lvl = 2'b00;
	logic pready_o, pslverr_o, comp1_out_i, comp2_out_i, analog_option_bit_i = 1'b0;
	logic hold_select_i = 1'b0, second_sample_hold_select_i = 1'b0, pin4_direction_i = 1'b0;
	logic pin4_data_i = 1'b0, output_level_bit_i = 1'b0;
	acc_pkg::acc_analog_t analog_o;
	int err_total = 0, n_compared = 0;
	always #2 clock_i = ~clock_i;
	acc_analog_ctrl acc_analog_ctrl_inst (.clock_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .comp1_out_i,
		.comp2_out_i, .analog_option_bit_i, .hold_select_i, .second_sample_hold_select_i,
		.pin4_direction_i, .pin4_data_i, .output_level_bit_i, .analog_o);
	acc_far_model acc_far_model_inst (.clock_i, .level_i(lvl), .analog_i(analog_o),
		.comp1_out_o(comp1_out_i), .comp2_out_o(comp2_out_i));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// bus master holds everything until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= {24'h0, d};
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		q = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(q, e);
		// no error response is ever given
		chk(32'(pslverr_o), 32'h0);
	endtask
	task close_out;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		cyc(8);
		srst_i <= 1'b0;
		rd(CTRL, 32'h0);
		rd(STAT, 32'h0);
		foreach (rows[i]) begin
			apb(1'b1, CTRL, rows[i].wr);
			chk(32'(analog_o), 32'(rows[i].ana));
			rd(CTRL, {24'h0, rows[i].wr});
		end
		// ramp first, then comparators, then discard stale flags
		apb(1'b1, CTRL, 8'h04);
		apb(1'b1, CTRL, 8'h0F);
		apb(1'b1, STAT, 8'h0C);
		for (int i = 0; i < 2; i++) begin
			lvl[i] <= 1'b1;
			cyc(6);
			rd(STAT, 32'h41 << i);
			chk(32'(analog_o.irq), 32'h1);
			lvl[i] <= 1'b0;
			cyc(6);
			rd(STAT, 32'h1 << i);
			apb(1'b1, STAT, 8'h08 >> i);
			rd(STAT, 32'h1 << i);
			apb(1'b1, STAT, 8'h04 << i);
			rd(STAT, 32'h0);
			chk(32'(analog_o.irq), 32'h0);
		end
		apb(1'b1, STAT, 8'h30);
		rd(STAT, 32'h0);
		analog_option_bit_i <= 1'b1;
		pin4_direction_i <= 1'b1;
		apb(1'b1, STAT, 8'h30);
		rd(STAT, 32'h30);
		chk(32'(analog_o.sample_offset), 32'h1);
		lvl[0] <= 1'b1;
		cyc(6);
		chk(32'(analog_o.pin4_out), 32'h1);
		analog_option_bit_i <= 1'b0;
		cyc(2);
		chk(32'(analog_o.pin4_out), 32'h0);
		chk(32'(analog_o.sample_offset), 32'h0);
		lvl[0] <= 1'b0;
		analog_option_bit_i <= 1'b1;
		hold_select_i <= 1'b1;
		cyc(2);
		chk(32'(analog_o.sample_offset), 32'h0);
		analog_option_bit_i <= 1'b0;
		output_level_bit_i <= 1'b1;
		cyc(2);
		chk(32'(analog_o.pin4_out), 32'h1);
		rd(STAT, 32'h1);
		// unmapped place: write dropped, read empty
		apb(1'b1, 8'h08, 8'hFF);
		rd(8'h08, 32'h0);
		rd(CTRL, 32'h0F);
		srst_i <= 1'b1;
		cyc(2);
		srst_i <= 1'b0;
		rd(CTRL, 32'h0);
		rd(STAT, 32'h0);
		close_out;
	end
	initial begin
		#20000;
		err_total++;
		close_out;
	end
endmodule // tb_top
bind acc_analog_ctrl acc_analog_ctrl_properties acc_analog_ctrl_properties_inst (.clock_i,
	.srst_i, .psel_i, .penable_i, .paddr_i, .pready_o, .prdata_o, .analog_option_bit_i,
	.hold_select_i, .second_sample_hold_select_i, .pin4_data_i, .output_level_bit_i, .analog_o);
